// ---- dmds_regs.vh ----
// Register map, item codes, reset values and timing counts.
`ifndef DMDS_REGS_VH
`define DMDS_REGS_VH
`define DMDS_OFS_CTRL      8'h00
`define DMDS_OFS_STARTUP   8'h04
`define DMDS_OFS_STATUS    8'h08
`define DMDS_OFS_ITEM      8'h0C
`define DMDS_OFS_SEG       8'h10
`define DMDS_OFS_VALUE     8'h14
`define DMDS_STARTUP_RST   12'hFFF
`define DMDS_STARTUP_RUN   12'hFFF
`define DMDS_ITEM_SPEED    12'h000
`define DMDS_ITEM_SPDCMD   12'h001
`define DMDS_ITEM_TORQUE   12'h002
`define DMDS_ITEM_ANGLE1   12'h003
`define DMDS_ITEM_ANGLE2   12'h004
`define DMDS_ITEM_INSTAT   12'h005
`define DMDS_ITEM_OUTSTAT  12'h006
`define DMDS_ITEM_PULSPD   12'h007
`define DMDS_ITEM_DEV      12'h008
`define DMDS_ITEM_LOAD     12'h009
`define DMDS_ITEM_CMDCNT   12'h00C
`define DMDS_ITEM_MFBCNT   12'h00D
`define DMDS_ITEM_EFBCNT   12'h00E
`define DMDS_ITEM_OPTIME   12'h012
`define DMDS_ITEM_FBCNT32  12'h013
`define DMDS_HOLD_MS       1000
`define DMDS_CLK_MHZ       100
`define DMDS_HOLD_CYC      (`DMDS_HOLD_MS * 1000 * `DMDS_CLK_MHZ)
`define DMDS_LOAD_S        10
`endif

// ---- dmds_display_select.v ----
// Monitor item selection and segment status display with AHB-Lite access.
//
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "dmds_regs.vh"
// What this block does
// - Input off lights the upper segment.
// - Input on lights the lower segment.
// - Output off lights the upper segment.
// - Output on lights the lower segment.
// - Default input LED mapping, home switch first.
// - Default output LED mapping, alarm first.
// - One-second set-key hold on item 005 or 006 toggles live status view.
// - Startup item select, FFF shows run state.
// - Torque shown as percent of rated.
// - Load ratio is effective torque over ten seconds.
// - Feedback counters count quadrature, four per line.
// - Pulse speed and deviation valid in position control.
// - Angle and pulse counters are 32-bit decimal.
// - Second angle is electrical degrees from origin.
module dmds_display_select
#(
   parameter [31:0] HOLD_CYCLES = `DMDS_HOLD_CYC
)
(
   // Clock and reset.
   input  wire        sys_clk,
   input  wire        rst,
   // AHB-Lite slave.
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // Operator panel.
   input  wire        set_key,
   input  wire        mode_up_key,
   input  wire        mode_down_key,
   output reg  [7:0]  seg_upper,
   output reg  [7:0]  seg_lower,
   output reg         show_status,
   output reg         show_run_state,
   output reg  [11:0] shown_item,
   output reg  [31:0] shown_value,
   output reg         shown_valid,
   // Drive I/O pins, low level means the signal is on.
   input  wire        home_switch_input_n,
   input  wire        probe1_input_n,
   input  wire        forward_overtravel_n,
   input  wire        reverse_overtravel_n,
   input  wire        probe2_input_n,
   input  wire [1:0]  spare_input_n,
   input  wire        ext24v_present_n,
   input  wire        alarm_output_n,
   input  wire        brake_output_n,
   input  wire [2:0]  gp_output_n,
   // Drive internal monitor sources.
   input  wire        position_control,
   input  wire [31:0] motor_speed,
   input  wire [31:0] speed_command,
   input  wire [31:0] torque_pct,
   input  wire [31:0] pulse_rotation_angle,
   input  wire [31:0] electrical_rotation_angle,
   input  wire [31:0] command_pulse_speed,
   input  wire [31:0] position_deviation_counter,
   input  wire [31:0] accumulated_load_ratio,
   input  wire [31:0] command_pulse_counter,
   input  wire [31:0] feedback_counter_cmd,
   input  wire [31:0] total_operation_time,
   input  wire        mot_enc_a,
   input  wire        mot_enc_b,
   input  wire        ext_enc_a,
   input  wire        ext_enc_b
);

   reg  [11:0] startup_reg;
   reg  [11:0] item_reg;
   reg         status_view_reg;
   reg  [31:0] hold_cnt_reg;
   reg         hold_done_reg;
   reg         up_q_reg;
   reg         dn_q_reg;
   reg         ap_wr_reg;
   reg         ap_rd_reg;
   reg  [7:0]  ap_addr_reg;
   reg  [31:0] mfb_cnt_reg;
   reg  [31:0] efb_cnt_reg;
   reg  [1:0]  mq_reg;
   reg  [1:0]  eq_reg;
   reg  [7:0]  pins_on;
   reg  [7:0]  outs_on;
   reg  [31:0] value_next;
   reg         valid_next;
   reg  [31:0] rd_next;
   wire        ap_valid;
   wire        hold_hit;

   // Pin positions; LED1 is bit 0 of each bank.
   always @*
   begin
      pins_on = {~ext24v_present_n, ~spare_input_n, ~probe2_input_n,
                 ~reverse_overtravel_n, ~forward_overtravel_n,
                 ~probe1_input_n, ~home_switch_input_n};
      outs_on = {3'h0, ~gp_output_n, ~brake_output_n,
                 ~alarm_output_n};
   end

   // Quadrature decoders; every edge of either phase is one count.
   function [31:0] dmds_quad;
      input [31:0] cnt;
      input [1:0]  prev;
      input [1:0]  now;
      begin
         case ({prev, now})
            4'h1, 4'h7, 4'hE, 4'h8: dmds_quad = cnt + 32'h1;
            4'h2, 4'hB, 4'hD, 4'h4: dmds_quad = cnt - 32'h1;
            default:                dmds_quad = cnt;
         endcase
      end
   endfunction

   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         mq_reg      <= 2'h0;
         eq_reg      <= 2'h0;
         mfb_cnt_reg <= 32'h0;
         efb_cnt_reg <= 32'h0;
      end
      else
      begin
         mq_reg      <= {mot_enc_a, mot_enc_b};
         eq_reg      <= {ext_enc_a, ext_enc_b};
         mfb_cnt_reg <= dmds_quad(mfb_cnt_reg, mq_reg,
                                  {mot_enc_a, mot_enc_b});
         efb_cnt_reg <= dmds_quad(efb_cnt_reg, eq_reg,
                                  {ext_enc_a, ext_enc_b});
      end
   end

   // The set key must stay down a full second; the count fires once per hold.
   assign hold_hit = set_key && !hold_done_reg &&
                     (hold_cnt_reg == HOLD_CYCLES - 32'h1);

   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         hold_cnt_reg  <= 32'h0;
         hold_done_reg <= 1'b0;
      end
      else if (!set_key)
      begin
         hold_cnt_reg  <= 32'h0;
         hold_done_reg <= 1'b0;
      end
      else if (hold_hit)
         hold_done_reg <= 1'b1;
      else if (!hold_done_reg)
         hold_cnt_reg  <= hold_cnt_reg + 32'h1;
   end

   // AHB address phase capture; single word transfers only.
   assign ap_valid = hsel && htrans[1] && hready;

   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         ap_wr_reg   <= 1'b0;
         ap_rd_reg   <= 1'b0;
         ap_addr_reg <= 8'h00;
      end
      else
      begin
         ap_wr_reg   <= ap_valid && hwrite;
         ap_rd_reg   <= ap_valid && !hwrite;
         ap_addr_reg <= haddr[7:0];
      end
   end

   // Item selection: startup value loads at reset, keys step it later.
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         startup_reg     <= `DMDS_STARTUP_RST;
         item_reg        <= `DMDS_STARTUP_RST;
         status_view_reg <= 1'b0;
         up_q_reg        <= 1'b0;
         dn_q_reg        <= 1'b0;
      end
      else
      begin
         up_q_reg <= mode_up_key;
         dn_q_reg <= mode_down_key;
         if (ap_wr_reg && ap_addr_reg == `DMDS_OFS_STARTUP)
            startup_reg <= hwdata[11:0];
         if (ap_wr_reg && ap_addr_reg == `DMDS_OFS_ITEM)
            item_reg <= hwdata[11:0];
         else if (!status_view_reg && mode_up_key && !up_q_reg)
            item_reg <= item_reg + 12'h1;
         else if (!status_view_reg && mode_down_key && !dn_q_reg)
            item_reg <= item_reg - 12'h1;
         if (ap_wr_reg && ap_addr_reg == `DMDS_OFS_CTRL && hwdata[0])
            item_reg <= startup_reg;
         if (hold_hit && (item_reg == `DMDS_ITEM_INSTAT ||
                          item_reg == `DMDS_ITEM_OUTSTAT))
            status_view_reg <= !status_view_reg;
      end
   end

   // Monitor value mux for the selected item.
   always @*
   begin
      value_next = 32'h0;
      valid_next = 1'b1;
      case (item_reg)
         `DMDS_ITEM_SPEED:   value_next = motor_speed;
         `DMDS_ITEM_SPDCMD:  value_next = speed_command;
         `DMDS_ITEM_TORQUE:  value_next = torque_pct;
         `DMDS_ITEM_ANGLE1:  value_next = pulse_rotation_angle;
         `DMDS_ITEM_ANGLE2:  value_next = electrical_rotation_angle;
         `DMDS_ITEM_INSTAT:  value_next = {24'h0, pins_on};
         `DMDS_ITEM_OUTSTAT: value_next = {24'h0, outs_on};
         `DMDS_ITEM_PULSPD:
         begin
            value_next = command_pulse_speed;
            valid_next = position_control;
         end
         `DMDS_ITEM_DEV:
         begin
            value_next = position_deviation_counter;
            valid_next = position_control;
         end
         `DMDS_ITEM_LOAD:    value_next = accumulated_load_ratio;
         `DMDS_ITEM_CMDCNT:  value_next = command_pulse_counter;
         `DMDS_ITEM_MFBCNT:  value_next = mfb_cnt_reg;
         `DMDS_ITEM_EFBCNT:  value_next = efb_cnt_reg;
         `DMDS_ITEM_OPTIME:  value_next = total_operation_time;
         `DMDS_ITEM_FBCNT32: value_next = feedback_counter_cmd;
         default:            valid_next = 1'b0;
      endcase
   end

   // Panel outputs; status segments follow the pins every cycle.
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         seg_upper      <= 8'h00;
         seg_lower      <= 8'h00;
         show_status    <= 1'b0;
         show_run_state <= 1'b0;
         shown_item     <= 12'h000;
         shown_value    <= 32'h0;
         shown_valid    <= 1'b0;
      end
      else
      begin
         if (status_view_reg && item_reg == `DMDS_ITEM_INSTAT)
         begin
            seg_upper <= ~pins_on;
            seg_lower <= pins_on;
         end
         else if (status_view_reg)
         begin
            seg_upper <= ~outs_on;
            seg_lower <= outs_on;
         end
         else
         begin
            seg_upper <= 8'h00;
            seg_lower <= 8'h00;
         end
         show_status    <= status_view_reg;
         show_run_state <= (item_reg == `DMDS_STARTUP_RUN);
         shown_item     <= item_reg;
         shown_value    <= value_next;
         shown_valid    <= valid_next;
      end
   end

   // Read data; unmapped offsets read zero.
   always @*
   begin
      case (ap_addr_reg)
         `DMDS_OFS_STARTUP: rd_next = {20'h0, startup_reg};
         `DMDS_OFS_STATUS:  rd_next = {30'h0, valid_next, status_view_reg};
         `DMDS_OFS_ITEM:    rd_next = {20'h0, item_reg};
         `DMDS_OFS_SEG:     rd_next = {16'h0, outs_on, pins_on};
         `DMDS_OFS_VALUE:   rd_next = value_next;
         default:           rd_next = 32'h0;
      endcase
   end

   // Each read costs one wait state, so that a write from the previous
   // data phase has landed before the register is copied out.
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         hrdata    <= 32'h0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= !(ap_valid && !hwrite);
         hresp     <= 1'b0;
         if (ap_rd_reg)
            hrdata <= rd_next; // Holds until the next read.
      end
   end

endmodule // dmds_display_select
`default_nettype wire

// ---- dmds_display_select_sva.sv ----
// Port checks for the monitor display selector.
`timescale 1ns/1ps
`default_nettype none
module dmds_display_select_sva
#(
   parameter [31:0] HOLD_CYCLES = 32'h10
)
(
   // Clock and reset.
   input wire logic        sys_clk,
   input wire logic        rst,
   // Bus, keys, control mode and display.
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        set_key,
   input wire logic        position_control,
   input wire logic        show_status,
   input wire logic        show_run_state,
   input wire logic        shown_valid,
   input wire logic [11:0] shown_item,
   input wire logic [7:0]  seg_upper,
   input wire logic [7:0]  seg_lower
);
   logic [31:0] held_cnt;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Unbroken press length; it saturates so a stuck key never wraps.
   always @(posedge sys_clk)
   begin
      if (rst || !set_key)
         held_cnt <= 32'h0;
      else if (held_cnt != 32'hFFFF_FFFF)
         held_cnt <= held_cnt + 32'h1;
   end
   sequence calm_s;
      $stable(shown_item) && $stable(position_control);
   endsequence
   sequence idle_key_s;
      !set_key [*4];
   endsequence
   bus_okay_a: assert property (!hresp)
      else $error("bus answer not okay");
   wait_short_a: assert property (!hreadyout |=> hreadyout)
      else $error("bus wait longer than one cycle");
   seg_dark_a: assert property (!show_status && !$past(show_status) |->
      {seg_upper, seg_lower} == 16'h0) else $error("segments lit");
   seg_pair_a: assert property (show_status && $past(show_status) |->
      seg_upper == ~seg_lower) else $error("segment pair wrong");
   view_item_a: assert property (show_status |->
      shown_item == 12'h005 || shown_item == 12'h006)
      else $error("status view on wrong item");
   run_state_a: assert property (!$past(rst) && $stable(shown_item)
      |-> show_run_state == (shown_item == 12'hFFF))
      else $error("run state flag wrong");
   hold_need_a: assert property (!$past(rst) && $changed(show_status)
      |-> $past(held_cnt, 3) >= HOLD_CYCLES - 32'h4)
      else $error("view toggled without a long hold");
   key_quiet_a: assert property (idle_key_s |-> $stable(show_status))
      else $error("view toggled with key released");
   pos_valid_a: assert property (calm_s [*3] ##0 shown_item == 12'h008
      |-> shown_valid == position_control) else $error("valid flag wrong");
endmodule // dmds_display_select_sva
bind dmds_display_select dmds_display_select_sva
   #(.HOLD_CYCLES(HOLD_CYCLES)) u_sva (.sys_clk(sys_clk), .rst(rst),
   .hreadyout(hreadyout), .hresp(hresp), .set_key(set_key),
   .position_control(position_control), .show_status(show_status),
   .show_run_state(show_run_state), .shown_valid(shown_valid),
   .shown_item(shown_item), .seg_upper(seg_upper), .seg_lower(seg_lower));
`default_nettype wire

// ---- dmds_operator_model.sv ----
// Operator at the panel, pressing keys for chosen lengths of time.
`timescale 1ns/1ps
`default_nettype none
module dmds_operator_model
(
   // Clock.
   input  wire logic sys_clk,
   // Panel keys.
   output var logic  set_key,
   output var logic  mode_up_key,
   output var logic  mode_down_key
);
   // All keys start released.
   initial
   begin
      set_key = 1'b0;
      mode_up_key = 1'b0;
      mode_down_key = 1'b0;
   end
   // Holds set for n cycles; a short n is a press too brief to count.
   task automatic hold_set(input int n);
      @(posedge sys_clk);
      set_key <= 1'b1;
      repeat (n) @(posedge sys_clk);
      set_key <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask
   // One tap of the up or the down key.
   task automatic step(input logic up);
      @(posedge sys_clk);
      mode_up_key <= up;
      mode_down_key <= !up;
      repeat (2) @(posedge sys_clk);
      mode_up_key <= 1'b0;
      mode_down_key <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask
endmodule // dmds_operator_model
`default_nettype wire

// ---- test_drive_monitor_display_select.sv ----
// Self-checking bench for the monitor display selector.
`timescale 1ns/1ps
`default_nettype none
`include "dmds_regs.vh"
module test_drive_monitor_display_select;
   logic        sys_clk, rst, hsel, hwrite, posc;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, mon, rdat;
   logic [7:0]  in_n, m;
   logic [4:0]  out_n;
   logic [3:0]  enc;
   logic [31:0] mv [20];
   logic [11:0] its [10] = '{12'h001, 12'h002, 12'h003, 12'h004, 12'h007,
                             12'h008, 12'h009, 12'h00C, 12'h012, 12'h013};
   logic [1:0]  gq [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
   wire         hreadyout, hresp, skey, ukey, dkey, sst, srun, sval;
   wire [7:0]   su, sl;
   wire [11:0]  sitem;
   wire [31:0]  hrdata, sv;
   int          err_count, n_tests;
   // Design, with a short hold count so key tests stay brief.
   dmds_display_select #(.HOLD_CYCLES(32'h10)) u_dut (.sys_clk(sys_clk),
      .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .set_key(skey), .mode_up_key(ukey), .mode_down_key(dkey),
      .seg_upper(su), .seg_lower(sl), .show_status(sst),
      .show_run_state(srun), .shown_item(sitem), .shown_value(sv),
      .shown_valid(sval), .home_switch_input_n(in_n[0]),
      .probe1_input_n(in_n[1]), .forward_overtravel_n(in_n[2]),
      .reverse_overtravel_n(in_n[3]), .probe2_input_n(in_n[4]),
      .spare_input_n(in_n[6:5]), .ext24v_present_n(in_n[7]),
      .alarm_output_n(out_n[0]), .brake_output_n(out_n[1]),
      .gp_output_n(out_n[4:2]), .position_control(posc),
      .motor_speed(mv[0]), .speed_command(mv[1]),
      .torque_pct(mv[2]), .pulse_rotation_angle(mv[3]),
      .electrical_rotation_angle(mv[4]),
      .command_pulse_speed(mv[7]),
      .position_deviation_counter(mv[8]),
      .accumulated_load_ratio(mv[9]),
      .command_pulse_counter(mv[12]),
      .feedback_counter_cmd(mv[19]),
      .total_operation_time(mv[18]), .mot_enc_a(enc[1]),
      .mot_enc_b(enc[0]), .ext_enc_a(enc[3]), .ext_enc_b(enc[2]));
   dmds_operator_model u_op (.sys_clk(sys_clk), .set_key(skey),
      .mode_up_key(ukey), .mode_down_key(dkey));
   // Free-running system clock.
   always #5 sys_clk = ~sys_clk;
   // One compare for every kind of result.
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e)
      begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Single AHB-Lite word transfer; read data lands in rdat.
   task automatic xfer(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rdat = hrdata;
      hsel <= 1'b0;
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Cuts a hang short; the tests need a few hundred cycles.
   initial
   begin
      #200000;
      err_count++;
      final_report;
   end
   // Main test sequence.
   initial
   begin
      {sys_clk, hsel, hwrite, htrans, haddr, hwdata, enc} = '0;
      {rst, posc, in_n, out_n} = '1;
      hsize = 3'h2;
      mon = 32'h1234_5678;
      foreach (mv[k]) mv[k] = mon + 32'(k);
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      xfer(`DMDS_OFS_STARTUP, 1'b0, 32'h0);
      chk(rdat, 32'h0000_0FFF);
      xfer(8'h20, 1'b0, 32'h0);
      chk(rdat, 32'h0);
      chk({19'h0, srun, sitem}, 32'h0000_1FFF);
      $display("reset test done");
      foreach (its[i])
      begin
         xfer(`DMDS_OFS_ITEM, 1'b1, {20'h0, its[i]});
         repeat (3) @(posedge sys_clk);
         chk(sv, mon + {20'h0, its[i]});
         xfer(`DMDS_OFS_VALUE, 1'b0, 32'h0);
         chk(rdat, mon + {20'h0, its[i]});
      end
      xfer(`DMDS_OFS_ITEM, 1'b1, 32'h0000_0008);
      posc <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk({31'h0, sval}, 32'h0);
      posc <= 1'b1;
      foreach (gq[i])
      begin
         enc <= {gq[i], gq[i]};
         repeat (4) @(posedge sys_clk);
      end
      xfer(`DMDS_OFS_ITEM, 1'b1, 32'h0000_000D);
      repeat (3) @(posedge sys_clk);
      chk(sv, 32'h4);
      xfer(`DMDS_OFS_ITEM, 1'b1, 32'h0000_000E);
      repeat (3) @(posedge sys_clk);
      chk(sv, 32'h4);
      xfer(`DMDS_OFS_STARTUP, 1'b1, 32'h0000_0003);
      xfer(`DMDS_OFS_CTRL, 1'b1, 32'h0000_0001);
      repeat (3) @(posedge sys_clk);
      chk({20'h0, sitem}, 32'h3);
      $display("value test done");
      xfer(`DMDS_OFS_ITEM, 1'b1, 32'h0000_0006);
      u_op.step(1'b0);
      chk({20'h0, sitem}, 32'h5);
      u_op.hold_set(8);
      chk({31'h0, sst}, 32'h0);
      u_op.hold_set(20);
      chk({31'h0, sst}, 32'h1);
      xfer(`DMDS_OFS_STATUS, 1'b0, 32'h0);
      chk(rdat, 32'h3);
      for (int i = 0; i < 8; i++)
      begin
         m = 8'h01 << i;
         in_n <= ~m;
         repeat (3) @(posedge sys_clk);
         chk({16'h0, su, sl}, {16'h0, ~m, m});
         xfer(`DMDS_OFS_SEG, 1'b0, 32'h0);
         chk(rdat, {24'h0, m});
      end
      u_op.hold_set(20);
      chk({31'h0, sst}, 32'h0);
      u_op.step(1'b1);
      u_op.hold_set(20);
      for (int i = 0; i < 5; i++)
      begin
         m = 8'h01 << i;
         out_n <= ~m[4:0];
         repeat (3) @(posedge sys_clk);
         chk({16'h0, su, sl}, {16'h0, ~m, m});
         xfer(`DMDS_OFS_SEG, 1'b0, 32'h0);
         chk(rdat, {16'h0, m, 8'h80});
      end
      u_op.hold_set(20);
      chk({31'h0, sst}, 32'h0);
      $display("status test done");
      final_report;
   end
endmodule // test_drive_monitor_display_select
`default_nettype wire
